// [logic/sarc_pkg.sv]
// constants, register layouts and types for the auxiliary audio port receive block
package sarc_pkg;

   localparam logic [7:0] SARC_TIMING_ADDR = 8'h26;
   localparam logic [7:0] SARC_PINSEL_ADDR = 8'h27;
   localparam logic [7:0] SARC_CH1_ADDR = 8'h28;
   localparam logic [7:0] SARC_TIMING_RESET = 8'h00;
   localparam logic [7:0] SARC_PINSEL_RESET = 8'h00;
   localparam logic [7:0] SARC_READ_ZERO = 8'h00;
   localparam logic [1:0] SARC_RESV_ZERO = 2'h0;
   localparam logic SARC_CH_EN_RESET = 1'h0;

   localparam int SARC_CHANNELS = 8;
   localparam int SARC_WORD_BITS = 32;
   localparam int SARC_SLOT_MAX = 32;
   localparam int SARC_DELAY_MAX = 31;
   localparam int SARC_I2S_LEAD = 1;

   typedef struct packed {
      logic aux_rx_sample_edge;
      logic aux_rx_local_frame_sync_sel;
      logic aux_rx_local_bit_clock_sel;
      logic [4:0] aux_rx_msb_delay;
   } sarc_timing_s;

   typedef struct packed {
      logic [1:0] reserved;
      logic enable;
      logic [4:0] slot;
   } sarc_chcfg_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sarc_reg_req_s;

   typedef enum logic [1:0] {
      SARC_TDM,
      SARC_I2S,
      SARC_LJ
   } sarc_format_e;

endpackage

// [logic/sarc_top.sv]
// receive side of the auxiliary audio port: config registers and slot capture
//
// How it works
// - edge bit clear: sample data on the default edge set by bit clock polarity.
// - edge bit set: sample on the opposite edge, half a bit clock later.
// - controller mode: bit 6 picks local (1) or external (0) frame sync.
// - controller mode: bit 5 picks local (1) or external (0) bit clock.
// - five-bit msb delay field; zero keeps the standard msb position.
// - delay N shifts slot-0 msb by N bit clocks, on both data pins.
// - i2s and left-justified: delay applies to left and right halves.
// - pin-select bit per channel: 0 takes data pin a, 1 pin b.
// - both receive config registers reset to zero.
// - per-channel enable gates capture; set delivers the word downstream.
// - slot 0-15 is tdm slot or left slot, 16-31 tdm or right.
`timescale 1ns/1ps
module sarc_top
   import sarc_pkg::*;
#(
   parameter int WORD_BITS = SARC_WORD_BITS,
   parameter int CHANNELS = SARC_CHANNELS
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire sarc_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic controller_mode,
   input wire logic bit_clock_polarity,
   input wire sarc_format_e rx_format,
   input wire logic local_bit_clock,
   input wire logic local_frame_sync,
   input wire logic ext_bit_clock,
   input wire logic ext_frame_sync,
   input wire logic serial_in_a,
   input wire logic serial_in_b,
   output logic [CHANNELS-1:0][WORD_BITS-1:0] rx_word,
   output logic [CHANNELS-1:0] rx_word_valid
);

   localparam int WB = $clog2(WORD_BITS);
   localparam int CW = $clog2(SARC_SLOT_MAX * WORD_BITS + SARC_DELAY_MAX + 2) + 1;
   localparam int SW = CW - WB;
   localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};
   localparam logic [WB-1:0] LAST_BIT = WB'(WORD_BITS - 1);

   // pin order inside the synchroniser
   localparam int P_BCLK = 3;
   localparam int P_FS = 2;
   localparam int P_A = 1;
   localparam int P_B = 0;

   sarc_timing_s timing;
   logic [7:0] pin_sel;
   sarc_chcfg_s ch_cfg [CHANNELS];

   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic bclk_prev;
   logic fs_prev;
   logic [CW-1:0] bit_cnt;
   logic half_q;

   logic use_local_bclk;
   logic use_local_fs;
   logic bclk_now;
   logic fs_now;
   logic rise;
   logic fall;
   logic sample_on_rise;
   logic strobe;
   logic restart;
   logic half_cur;
   logic [CW-1:0] cur;
   logic [CW-1:0] lead;
   logic [CW-1:0] pos;
   logic in_range;
   logic [SW-1:0] slot_idx;
   logic [WB-1:0] bit_idx;
   logic [WORD_BITS-1:0] shreg [CHANNELS];
   logic [7:0] next_rdata;

   function automatic logic [7:0] ch_addr(input int i);
      ch_addr = SARC_CH1_ADDR + 8'(i);
   endfunction

   // channel slot number against current slot and half
   function automatic logic slot_hit(
      input sarc_chcfg_s c,
      input sarc_format_e f,
      input logic half,
      input logic [SW-1:0] sidx
   );
      logic [SW-1:0] want;
      want = '0;
      if (f == SARC_TDM) begin
         want = SW'(c.slot);
         slot_hit = c.enable && (sidx == want);
      end else begin
         want = SW'(c.slot[3:0]);
         slot_hit = c.enable && (c.slot[4] == half) && (sidx == want);
      end
   endfunction

   // register writes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timing <= SARC_TIMING_RESET;
         pin_sel <= SARC_PINSEL_RESET;
         for (int i = 0; i < CHANNELS; i++) begin
            ch_cfg[i] <= {SARC_RESV_ZERO, SARC_CH_EN_RESET, 5'(i)};
         end
      end else if (reg_req.wr) begin
         if (reg_req.addr == SARC_TIMING_ADDR) begin
            timing <= reg_req.wdata;
         end
         if (reg_req.addr == SARC_PINSEL_ADDR) begin
            pin_sel <= reg_req.wdata;
         end
         for (int i = 0; i < CHANNELS; i++) begin
            if (reg_req.addr == ch_addr(i)) begin
               ch_cfg[i] <= {SARC_RESV_ZERO, reg_req.wdata[5:0]};
            end
         end
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      next_rdata = SARC_READ_ZERO;
      if (reg_req.addr == SARC_TIMING_ADDR) begin
         next_rdata = timing;
      end
      if (reg_req.addr == SARC_PINSEL_ADDR) begin
         next_rdata = pin_sel;
      end
      for (int i = 0; i < CHANNELS; i++) begin
         if (reg_req.addr == ch_addr(i)) begin
            next_rdata = ch_cfg[i];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= SARC_READ_ZERO;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_req.rd;
         if (reg_req.rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // pin synchroniser
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
      end else begin
         pin_s1 <= {ext_bit_clock, ext_frame_sync, serial_in_a, serial_in_b};
         pin_s2 <= pin_s1;
      end
   end

   // clock and frame sync source
   always_comb begin
      use_local_bclk = controller_mode & timing.aux_rx_local_bit_clock_sel;
      use_local_fs = controller_mode & timing.aux_rx_local_frame_sync_sel;
      bclk_now = use_local_bclk ? local_bit_clock : pin_s2[P_BCLK];
      fs_now = use_local_fs ? local_frame_sync : pin_s2[P_FS];
   end

   // sampling edge
   always_comb begin
      rise = bclk_now & ~bclk_prev;
      fall = ~bclk_now & bclk_prev;
      sample_on_rise = ~bit_clock_polarity;
      if (timing.aux_rx_sample_edge) begin
         sample_on_rise = bit_clock_polarity;
      end
      strobe = sample_on_rise ? rise : fall;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bclk_prev <= 1'b0;
      end else begin
         bclk_prev <= bclk_now;
      end
   end

   // frame position of the current sample
   always_comb begin
      if (rx_format == SARC_TDM) begin
         restart = fs_now & ~fs_prev;
      end else begin
         restart = fs_now ^ fs_prev;
      end
      if (!restart) begin
         half_cur = half_q;
      end else if (rx_format == SARC_I2S) begin
         half_cur = fs_now;
      end else if (rx_format == SARC_LJ) begin
         half_cur = ~fs_now;
      end else begin
         half_cur = 1'b0;
      end
      cur = restart ? '0 : bit_cnt;
      lead = (rx_format == SARC_I2S) ? CW'(SARC_I2S_LEAD) : '0;
      // both halves restart the count, so the delay covers each
      lead = lead + CW'(timing.aux_rx_msb_delay);
      in_range = (cur >= lead);
      pos = cur - lead;
      slot_idx = pos[CW-1:WB];
      bit_idx = pos[WB-1:0];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fs_prev <= 1'b0;
         bit_cnt <= CNT_MAX;
         half_q <= 1'b0;
      end else if (strobe) begin
         fs_prev <= fs_now;
         half_q <= half_cur;
         if (cur != CNT_MAX) begin
            bit_cnt <= cur + CW'(1);
         end else begin
            bit_cnt <= cur;
         end
      end
   end

   // per-channel capture
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_word <= '0;
         rx_word_valid <= '0;
         for (int i = 0; i < CHANNELS; i++) begin
            shreg[i] <= '0;
         end
      end else begin
         rx_word_valid <= '0;
         if (strobe && in_range && (bit_cnt != CNT_MAX || restart)) begin
            for (int i = 0; i < CHANNELS; i++) begin
               if (slot_hit(ch_cfg[i], rx_format, half_cur, slot_idx)) begin
                  logic din;
                  logic [WORD_BITS-1:0] nxt;
                  din = pin_sel[i] ? pin_s2[P_B] : pin_s2[P_A];
                  nxt = {shreg[i][WORD_BITS-2:0], din};
                  shreg[i] <= nxt;
                  if (bit_idx == LAST_BIT) begin
                     rx_word[i] <= nxt;
                     rx_word_valid[i] <= 1'b1;
                  end
               end
            end
         end
      end
   end

endmodule

// [dv/sarc_top_asserts.sv]
// checker for the auxiliary audio port receive block
`timescale 1ns/1ps
module sarc_top_asserts
   import sarc_pkg::*;
#(
   parameter int WORD_BITS = SARC_WORD_BITS,
   parameter int CHANNELS = SARC_CHANNELS
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire sarc_reg_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic [CHANNELS-1:0][WORD_BITS-1:0] rx_word,
   input wire logic [CHANNELS-1:0] rx_word_valid
);
   logic [7:0] sh_tim, sh_pin;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // shadow copies of the two config registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         {sh_tim, sh_pin} <= 16'h0000;
      end else if (reg_req.wr && reg_req.addr == SARC_TIMING_ADDR) begin
         sh_tim <= reg_req.wdata;
      end else if (reg_req.wr && reg_req.addr == SARC_PINSEL_ADDR) begin
         sh_pin <= reg_req.wdata;
      end
   end
   sequence s_rd_tim;
      reg_req.rd && reg_req.addr == SARC_TIMING_ADDR;
   endsequence
   sequence s_rd_pin;
      reg_req.rd && reg_req.addr == SARC_PINSEL_ADDR;
   endsequence
   property p_timing;
      s_rd_tim |=> reg_rdata == $past(sh_tim);
   endproperty
   property p_pinsel;
      s_rd_pin |=> reg_rdata == $past(sh_pin);
   endproperty
   property p_unmapped;
      reg_req.rd && (reg_req.addr < SARC_TIMING_ADDR || reg_req.addr > 8'h2F)
         |=> reg_rdata == SARC_READ_ZERO;
   endproperty
   property p_rvalid;
      reg_req.rd |=> reg_rvalid;
   endproperty
   property p_rv_cause;
      reg_rvalid |-> $past(reg_req.rd);
   endproperty
   property p_rdata_hold;
      !reg_rvalid |-> $stable(reg_rdata);
   endproperty
   property p_valid_pulse;
      |rx_word_valid |=> !(|rx_word_valid);
   endproperty
   property p_word_hold;
      rx_word[0] != $past(rx_word[0]) |-> rx_word_valid[0];
   endproperty
   a_timing: assert property (p_timing) else $error("timing readback");
   a_pinsel: assert property (p_pinsel) else $error("pin select readback");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   a_rvalid: assert property (p_rvalid) else $error("no read valid");
   a_rv_cause: assert property (p_rv_cause) else $error("stray read valid");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   a_valid_pulse: assert property (p_valid_pulse) else $error("long valid");
   a_word_hold: assert property (p_word_hold) else $error("word moved");
endmodule
bind sarc_top sarc_top_asserts #(.WORD_BITS(WORD_BITS), .CHANNELS(CHANNELS)) u_asserts (
   .mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .rx_word(rx_word), .rx_word_valid(rx_word_valid));

// [dv/sarc_host_model.sv]
// serial host driving frames into the auxiliary audio port
`timescale 1ns/1ps
module sarc_host_model (
   output logic bclk,
   output logic fs,
   output logic da,
   output logic db
);
   initial begin
      {bclk, fs, da, db} = 4'h0;
   end
   // inv: level before the sample edge; clock stands still between frames
   task automatic frame(input logic i2s, input logic inv, input int d,
      input logic [63:0] wa, input logic [63:0] wb);
      bclk = inv;
      for (int p = -1; p < d + 64; p++) begin
         fs = (p >= 0) ^ i2s;
         da = (p < d) ? ~da : wa[63 - (p - d)];
         db = (p < d) ? ~db : wb[63 - (p - d)];
         #16 bclk = ~inv;
         #16 bclk = inv;
      end
      // released lines do not keep the last bit
      da = ~da;
      db = ~db;
   endtask
endmodule

// [dv/secondary_audio_rx_config_tb_top.sv]
// self-checking bench for the auxiliary audio port receive block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end
module secondary_audio_rx_config_tb_top;
   import sarc_pkg::*;
   logic mclk, rst_n, pol, bclk, fs, da, db, cm;
   sarc_reg_req_s req;
   sarc_format_e fmt;
   logic [7:0] rdata;
   logic rvalid;
   logic [7:0][31:0] word;
   logic [7:0] wvalid;
   logic [31:0] seed = 32'h7FC9;
   int err_count, checked, cyc;
   sarc_top dut (.mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .controller_mode(cm), .bit_clock_polarity(pol),
      .rx_format(fmt), .local_bit_clock(1'h0), .local_frame_sync(1'h0),
      .ext_bit_clock(bclk), .ext_frame_sync(fs), .serial_in_a(da), .serial_in_b(db),
      .rx_word(word), .rx_word_valid(wvalid));
   sarc_host_model host (.bclk(bclk), .fs(fs), .da(da), .db(db));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] pick(logic sel, logic [31:0] x, logic [31:0] y);
      return sel ? y : x;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{a, d, 1'h1, 1'h0};
      @(posedge mclk);
      req.wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      req <= '{a, 8'h00, 1'h0, 1'h1};
      @(posedge mclk);
      req.rd <= 1'h0;
      @(negedge mclk);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      logic [7:0] t, s;
      logic [63:0] a, b;
      logic [31:0] w0;
      sarc_format_e f;
      {rst_n, pol, cm} = 3'h0;
      req = '0;
      fmt = SARC_TDM;
      repeat (8) @(posedge mclk);
      rst_n <= 1'h1;
      rd(SARC_TIMING_ADDR);
      `CHK(rdata, SARC_TIMING_RESET)
      rd(SARC_PINSEL_ADDR);
      `CHK(rdata, SARC_PINSEL_RESET)
      rd(8'h40);
      `CHK(rdata, SARC_READ_ZERO)
      wr(SARC_CH1_ADDR, 8'h20);
      wr(SARC_CH1_ADDR + 8'h01, 8'h21);
      for (int n = 0; n < 8; n++) begin
         t = 8'(xs());
         s = 8'(xs());
         a = {xs(), xs()};
         b = {xs(), xs()};
         f = sarc_format_e'(n % 3);
         if (n < 2) t[4:0] = n ? 5'h1F : 5'h00;
         wr(SARC_TIMING_ADDR, t);
         wr(SARC_PINSEL_ADDR, s);
         rd(SARC_TIMING_ADDR);
         `CHK(rdata, t)
         rd(SARC_PINSEL_ADDR);
         `CHK(rdata, s)
         @(posedge mclk);
         pol <= a[40];
         fmt <= f;
         host.frame(f == SARC_I2S, a[40] ^ t[7], int'(t[4:0]) + int'(f == SARC_I2S), a, b);
         repeat (20) @(posedge mclk);
         `CHK(word[0], pick(s[0], a[63:32], b[63:32]))
         `CHK(word[1], pick(s[1], a[31:0], b[31:0]))
      end
      // controller mode: external sources still work, tied-low local sources stop capture
      @(posedge mclk);
      cm <= 1'h1;
      pol <= 1'h0;
      fmt <= SARC_TDM;
      for (int m = 0; m < 3; m++) begin
         t = (m == 0) ? 8'h00 : ((m == 1) ? 8'h40 : 8'h20);
         wr(SARC_TIMING_ADDR, t);
         a = {xs(), xs()};
         b = {xs(), xs()};
         @(posedge mclk);
         host.frame(1'h0, 1'h0, 0, a, b);
         repeat (20) @(posedge mclk);
         if (m == 0) w0 = pick(s[0], a[63:32], b[63:32]);
         if (m < 2) `CHK(word[0], w0)
         else `CHK(word[0], w0)
      end
      final_report();
   end
endmodule
